// >>> ptap_pkg.sv
// Package with register map, field layouts and constants of the audio port.
package ptap_pkg;
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_DIV = 5'h04;
    localparam logic [4:0] ADDR_FDIV = 5'h08;
    localparam logic [4:0] ADDR_STAT = 5'h0C;
    localparam logic [4:0] ADDR_TX1 = 5'h10;
    localparam logic [4:0] ADDR_TX2 = 5'h14;
    localparam logic [4:0] ADDR_RX1 = 5'h18;
    localparam logic [4:0] ADDR_RX2 = 5'h1C;
    localparam logic [3:0] FULL_STRB = 4'hF;
    localparam int SLOT_BITS = 64;
    localparam int HALF_BASE = 32;
    localparam int PHASE_W = 16;
    localparam int CLK_DIV_W = 10;
    localparam int FRAME_W = 11;

    typedef struct packed {
        logic [15:0] rsvd;
        logic [4:0] chanDelay;
        logic [2:0] strobeLen;
        logic cntStop;
        logic mainSync;
        logic strobePos;
        logic edgeSel;
        logic clkInv;
        logic dblClk;
        logic master;
        logic enable;
    } ptap_ctrl_t;

    typedef struct packed {
        logic [FRAME_W-1:0] frameDiv;
        logic preSel;
        logic [9:0] preN;
        logic [CLK_DIV_W-1:0] clkDiv;
    } ptap_div_t;

    localparam ptap_ctrl_t CTRL_RST = '0;
    localparam ptap_div_t DIV_RST = '0;
    localparam logic [7:0] FDIV_RST = 8'h00;
endpackage : ptap_pkg

// >>> ptap_pcm_tdm_audio_port.sv
// Serial audio port: register slave, clock generation and slot engine.
// Operation
// - Master drives strobe over first slot.
// - Strobe high 1 bit, or 8 to 56 bits in steps of 8.
// - Strobe before or on first bit as slave, one bit earlier as master.
// - Frame rate divider; strobe event output.
// - Master drives bit clock, one/two per bit.
// - Clock invert flips bit clock polarity.
// - Slave takes strobe and clock as inputs.
// - Slave stops main counter until strobe rise.
// - Slave measures strobe phase to internal sync.
// - Two tx, two rx words, eight slots.
// - Data registers take full words only.
// - Channel delay up to 31 bytes.
// - Ten-bit divider plus one or N+1 predivider.
// - Fractional divider for exact average bit rate.
// - Main sync aligns strobe to main counter.
// - Enable low powers the interface down.
// - I2S right then left MSB timing.
// - I2S uses edge, length four, no delays.
// - TDM data delayed after both strobe edges.
// - Double clock mode samples second falling edge.
`timescale 1ns/1ps
`default_nettype none
module ptap_pcm_tdm_audio_port
    import ptap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [4:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mainTick,
    output logic mainCntStop,
    output logic frameEvent,
    input wire logic bitClkIn,
    output logic bitClkOut,
    output logic bitClkOe_n,
    input wire logic frameStrobeIn,
    output logic frameStrobeOut,
    output logic frameStrobeOe_n,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe_n
);
    ptap_ctrl_t ctrl_ff;
    ptap_div_t div_ff;
    logic [7:0] fdiv_ff;
    logic [31:0] txOne_ff, txTwo_ff, rxOne_ff, rxTwo_ff;
    logic [63:0] rxShadow_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff, wrEn, accOk;
    logic [9:0] preCnt_ff;
    logic [CLK_DIV_W-1:0] divCnt_ff;
    logic [7:0] fracAcc_ff;
    logic fracExtra_ff, clkInt_ff, lclkPrev_ff, bitPh_ff, fsPrev_ff;
    logic halfSel_ff, fsIn_prev_ff, syncPend_ff, stop_ff, evt_ff;
    logic [FRAME_W-1:0] frameCnt_ff, nxt_frameCnt, refCnt_ff, nxt_refCnt;
    logic [PHASE_W-1:0] phaseCnt_ff, phase_ff;
    logic [5:0] posR_ff;
    logic inSlotR_ff, doutR_ff, fsOutR_ff, clkOutR_ff;
    logic preTick, halfTick, lclk, launchEv, sampleEv, bitLaunch, sampleBit;
    logic fsLvl, fsRise, fsFall, nxt_half, frameWrap;
    logic [5:0] lenBits;
    logic [12:0] posFull;
    logic inSlot;
    logic [63:0] txAll;

    // Setup phase decodes; the access phase then completes with no wait.
    assign accOk = (paddr[1:0] == 2'b00) && (paddr <= ADDR_RX2);
    assign wrEn = psel && penable && pwrite && pready_ff && !pslverr_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel && !penable;
            // Byte lanes cannot be written alone; such a write is refused.
            pslverr_ff <= psel && !penable &&
                (!accOk || (pwrite && pstrb != FULL_STRB));
            case (paddr)
                ADDR_CTRL: prdata_ff <= ctrl_ff;
                ADDR_DIV: prdata_ff <= div_ff;
                ADDR_FDIV: prdata_ff <= {24'h00_0000, fdiv_ff};
                ADDR_STAT: prdata_ff <= {15'h0000, stop_ff, phase_ff};
                ADDR_TX1: prdata_ff <= txOne_ff;
                ADDR_TX2: prdata_ff <= txTwo_ff;
                ADDR_RX1: prdata_ff <= rxOne_ff;
                ADDR_RX2: prdata_ff <= rxTwo_ff;
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RST;
            div_ff <= DIV_RST;
            fdiv_ff <= FDIV_RST;
            txOne_ff <= 32'h0000_0000;
            txTwo_ff <= 32'h0000_0000;
        end else if (wrEn) begin
            case (paddr)
                ADDR_CTRL: ctrl_ff <= {16'h0000, pwdata[15:0]};
                ADDR_DIV: div_ff <= pwdata;
                ADDR_FDIV: fdiv_ff <= pwdata[7:0];
                ADDR_TX1: txOne_ff <= pwdata;
                ADDR_TX2: txTwo_ff <= pwdata;
                default: ;
            endcase
        end
    end

    // Predivider by one or N+1, then the ten-bit half-period divider.
    assign preTick = !div_ff.preSel || (preCnt_ff >= div_ff.preN);
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !ctrl_ff.enable || !ctrl_ff.master) begin
            preCnt_ff <= 10'h000;
        end else begin
            preCnt_ff <= preTick ? 10'h000 : preCnt_ff + 10'h001;
        end
    end

    // A fractional step stretches some half periods by one tick, so the
    // average bit rate can hit an even frame where integers cannot.
    assign halfTick = preTick && (divCnt_ff >= div_ff.clkDiv) && !fracExtra_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !ctrl_ff.enable || !ctrl_ff.master) begin
            divCnt_ff <= '0;
            fracAcc_ff <= 8'h00;
            fracExtra_ff <= 1'b0;
            clkInt_ff <= 1'b0;
        end else if (preTick) begin
            if (fracExtra_ff) begin
                fracExtra_ff <= 1'b0;
            end else if (halfTick) begin
                divCnt_ff <= '0;
                clkInt_ff <= !clkInt_ff;
                {fracExtra_ff, fracAcc_ff} <= {1'b0, fracAcc_ff} +
                    {1'b0, fdiv_ff};
            end else begin
                divCnt_ff <= divCnt_ff + 1'b1;
            end
        end
    end

    // Logical clock: data launches on its fall and is sampled on its rise, or on the second fall with double clock.
    assign lclk = ctrl_ff.master ? clkInt_ff :
        (bitClkIn ^ ctrl_ff.clkInv);
    assign launchEv = ctrl_ff.enable && !lclk && lclkPrev_ff;
    assign sampleEv = ctrl_ff.enable && lclk && !lclkPrev_ff;
    assign bitLaunch = launchEv && !(ctrl_ff.dblClk && bitPh_ff);
    assign sampleBit = ctrl_ff.dblClk ? (launchEv && bitPh_ff) :
        sampleEv;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lclkPrev_ff <= 1'b0;
            bitPh_ff <= 1'b0;
        end else begin
            lclkPrev_ff <= lclk;
            if (!ctrl_ff.dblClk) begin
                bitPh_ff <= 1'b0;
            end else if (launchEv) begin
                bitPh_ff <= !bitPh_ff;
            end
        end
    end

    // Master frame counter and strobe.
    assign lenBits = (ctrl_ff.strobeLen == 3'd0) ? 6'd1 :
        {ctrl_ff.strobeLen, 3'b000};
    assign frameWrap = (frameCnt_ff >= div_ff.frameDiv - 1'b1);
    always_comb begin
        nxt_frameCnt = frameCnt_ff + 1'b1;
        if (frameWrap) begin
            nxt_frameCnt = (ctrl_ff.mainSync && !syncPend_ff) ?
                frameCnt_ff : '0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !ctrl_ff.master || !ctrl_ff.enable) begin
            frameCnt_ff <= '0;
            fsOutR_ff <= 1'b0;
        end else if (bitLaunch) begin
            frameCnt_ff <= nxt_frameCnt;
            fsOutR_ff <= (nxt_frameCnt < FRAME_W'(lenBits)) &&
                !(frameWrap && nxt_frameCnt != '0);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            syncPend_ff <= 1'b0;
        end else if (mainTick) begin
            syncPend_ff <= 1'b1;
        end else if (bitLaunch && frameWrap) begin
            syncPend_ff <= 1'b0;
        end
    end

    // Slot reference restarts on strobe rise, and on its fall if selected.
    assign fsLvl = ctrl_ff.master ? fsOutR_ff : frameStrobeIn;
    assign fsRise = fsLvl && !fsPrev_ff;
    assign fsFall = !fsLvl && fsPrev_ff && ctrl_ff.edgeSel;
    always_comb begin
        nxt_refCnt = refCnt_ff + 1'b1;
        nxt_half = halfSel_ff;
        if (fsRise || fsFall) begin
            nxt_refCnt = '0;
            nxt_half = fsFall;
        end
    end
    // Strobe position 0 places data one bit after a received strobe edge, two bits after the master's driven one.
    assign posFull = {2'b00, nxt_refCnt} + (nxt_half ? 13'(HALF_BASE) : 13'd0)
        - {12'h000, !ctrl_ff.strobePos}
        - {5'h00, ctrl_ff.chanDelay, 3'b000};
    assign inSlot = (posFull < 13'(SLOT_BITS));
    assign txAll = {txOne_ff, txTwo_ff};
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !ctrl_ff.enable) begin
            fsPrev_ff <= 1'b0;
            refCnt_ff <= '1;
            halfSel_ff <= 1'b0;
            posR_ff <= 6'h00;
            inSlotR_ff <= 1'b0;
            doutR_ff <= 1'b0;
        end else if (bitLaunch) begin
            fsPrev_ff <= fsLvl;
            refCnt_ff <= (&refCnt_ff && !fsRise && !fsFall) ? refCnt_ff :
                nxt_refCnt;
            halfSel_ff <= nxt_half;
            posR_ff <= posFull[5:0];
            inSlotR_ff <= inSlot;
            doutR_ff <= inSlot ? txAll[6'd63 - posFull[5:0]] : 1'b0;
        end
    end

    // Received bits collect in a shadow that is published at frame start.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxShadow_ff <= 64'h0000_0000_0000_0000;
            rxOne_ff <= 32'h0000_0000;
            rxTwo_ff <= 32'h0000_0000;
        end else begin
            if (sampleBit && inSlotR_ff) begin
                rxShadow_ff[6'd63 - posR_ff] <= serialDataIn;
            end
            if (bitLaunch && fsRise) begin
                {rxOne_ff, rxTwo_ff} <= rxShadow_ff;
            end
        end
    end

    // Pins are released and quiet whenever the port is disabled.
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !ctrl_ff.enable) begin
            clkOutR_ff <= 1'b0;
            bitClkOe_n <= 1'b1;
            frameStrobeOe_n <= 1'b1;
            serialDataOe_n <= 1'b1;
            evt_ff <= 1'b0;
        end else begin
            clkOutR_ff <= clkInt_ff ^ ctrl_ff.clkInv;
            bitClkOe_n <= !ctrl_ff.master;
            frameStrobeOe_n <= !ctrl_ff.master;
            serialDataOe_n <= !inSlotR_ff;
            evt_ff <= bitLaunch && fsRise;
        end
    end

    // Phase from the internal sync tick to the received strobe rise.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fsIn_prev_ff <= 1'b0;
            phaseCnt_ff <= '0;
            phase_ff <= '0;
            stop_ff <= 1'b0;
        end else begin
            fsIn_prev_ff <= frameStrobeIn;
            phaseCnt_ff <= mainTick ? '0 : phaseCnt_ff + 1'b1;
            if (!ctrl_ff.master && frameStrobeIn && !fsIn_prev_ff) begin
                phase_ff <= phaseCnt_ff;
                stop_ff <= 1'b0;
            end else if (wrEn && paddr == ADDR_CTRL && pwdata[7] &&
                !pwdata[1]) begin
                stop_ff <= 1'b1;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign mainCntStop = stop_ff;
    assign frameEvent = evt_ff;
    assign bitClkOut = clkOutR_ff;
    assign frameStrobeOut = fsOutR_ff;
    assign serialDataOut = doutR_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_fsRiseSlave;
        !ctrl_ff.master && frameStrobeIn && !fsIn_prev_ff;
    endsequence
    property p_offQuiet;
        !ctrl_ff.enable |=> bitClkOe_n && frameStrobeOe_n && serialDataOe_n;
    endproperty
    a_offQuiet: assert property (p_offQuiet)
        else $error("pins driven while disabled");
    property p_masterDrive;
        ctrl_ff.enable && ctrl_ff.master |=> !bitClkOe_n && !frameStrobeOe_n;
    endproperty
    a_masterDrive: assert property (p_masterDrive)
        else $error("master not driving clock and strobe");
    property p_slaveRelease;
        !ctrl_ff.master |=> bitClkOe_n && frameStrobeOe_n;
    endproperty
    a_slaveRelease: assert property (p_slaveRelease)
        else $error("slave drives clock or strobe");
    property p_invert;
        ctrl_ff.enable && $stable(ctrl_ff) |=>
            bitClkOut == ($past(clkInt_ff) ^ $past(ctrl_ff.clkInv));
    endproperty
    a_invert: assert property (p_invert)
        else $error("clock polarity wrong");
    property p_stopResume;
        s_fsRiseSlave |=> !mainCntStop;
    endproperty
    a_stopResume: assert property (p_stopResume)
        else $error("counter not resumed on strobe");
    property p_phase;
        s_fsRiseSlave |=> phase_ff == $past(phaseCnt_ff);
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase not captured");
    property p_wordOnly;
        psel && !penable && pwrite && pstrb != FULL_STRB |=> pslverr;
    endproperty
    a_wordOnly: assert property (p_wordOnly)
        else $error("partial write not refused");
    property p_strobeShort;
        ctrl_ff.master && ctrl_ff.strobeLen == 3'd0 && bitLaunch &&
            nxt_frameCnt == 1 |=> !frameStrobeOut;
    endproperty
    a_strobeShort: assert property (p_strobeShort)
        else $error("one-bit strobe too long");
    property p_frameEvt;
        bitLaunch && fsRise && ctrl_ff.enable |=> frameEvent ##1 !frameEvent;
    endproperty
    a_frameEvt: assert property (p_frameEvt)
        else $error("frame event not one pulse");
endmodule : ptap_pcm_tdm_audio_port
`default_nettype wire

// >>> ptap_codec_model.sv
// Far-side codec model: clock and strobe source, data source or loopback.
`timescale 1ns/1ps
`default_nettype none
module ptap_codec_model #(
    parameter int HALF = 3,
    parameter int FRAME_BITS = 72
) (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [63:0] pattern,
    output logic bitClk,
    output logic strobe,
    output logic dataToDut,
    input wire logic dataFromDut,
    input wire logic dataFromDutOe_n
);
    int ph = 0;
    int bitIdx = 0;
    logic last = 1'b0;
    initial bitClk = 1'b0;
    // Clock is 40 MHz / 6 and stands still while no stream is wanted.
    always @(posedge clk_sys) begin
        if (!run) begin
            ph <= 0;
            bitIdx <= 0;
            bitClk <= 1'b0;
        end else begin
            ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
            if (ph == 0)
                bitClk <= 1'b1;
            if (ph == HALF) begin
                bitClk <= 1'b0;
                bitIdx <= (bitIdx == FRAME_BITS - 1) ? 0 : bitIdx + 1;
            end
        end
        last <= dataToDut;
    end
    // Strobe high for one bit, then low for the rest of the frame.
    assign strobe = run && (bitIdx == 0);
    // A released line toggles, so a stale level never passes for data.
    assign dataToDut = run ?
        ((bitIdx >= 1 && bitIdx <= 64) ? pattern[64 - bitIdx] : ~last) :
        (dataFromDutOe_n ? ~last : dataFromDut);
endmodule : ptap_codec_model
`default_nettype wire

// >>> ptap_pcm_tdm_audio_port_tb_top.sv
// Self-checking bench for the serial audio port.
`timescale 1ns/1ps
`default_nettype none
module ptap_pcm_tdm_audio_port_tb_top import ptap_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [4:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, mainCntStop, frameEvent;
    logic bitClkIn, bitClkOut, bitClkOe_n, pClk;
    logic frameStrobeIn, frameStrobeOut, frameStrobeOe_n, pStrobe;
    logic serialDataIn, serialDataOut, serialDataOe_n;
    logic mainTick = 1'b0;
    logic run = 1'b0;
    logic [63:0] pattern = 64'hC35A_96E1_0FF0_7B24;
    logic [31:0] rdata, rerr;
    logic prevClk, prevData, prevStb, watch = 1'b0, expLvl = 1'b0;
    int lenCnt = 0, lastLen = 0, gapCnt = 0, lastGap = 0;
    int edgeSeen = 0, edgeBad = 0, nErrors = 0, samplesChecked = 0;

    initial forever #12.5 clk_sys = ~clk_sys;
    // Shared pins take the level of whichever party enables its driver.
    assign bitClkIn = bitClkOe_n ? pClk : bitClkOut;
    assign frameStrobeIn = frameStrobeOe_n ? pStrobe : frameStrobeOut;

    ptap_pcm_tdm_audio_port dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mainTick(mainTick), .mainCntStop(mainCntStop),
        .frameEvent(frameEvent), .bitClkIn(bitClkIn), .bitClkOut(bitClkOut),
        .bitClkOe_n(bitClkOe_n), .frameStrobeIn(frameStrobeIn),
        .frameStrobeOut(frameStrobeOut), .frameStrobeOe_n(frameStrobeOe_n),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOe_n(serialDataOe_n));
    ptap_codec_model codec (.clk_sys(clk_sys), .run(run),
        .pattern(pattern), .bitClk(pClk), .strobe(pStrobe),
        .dataToDut(serialDataIn), .dataFromDut(serialDataOut),
        .dataFromDutOe_n(serialDataOe_n));

    // Strobe width in bit-clock rises, frame spacing, launch edge.
    always @(posedge clk_sys) begin
        prevClk <= bitClkOut;
        prevData <= serialDataOut;
        prevStb <= frameStrobeOut;
        if (frameStrobeOut && bitClkOut && !prevClk)
            lenCnt <= lenCnt + 1;
        if (!frameStrobeOut && prevStb) begin
            lastLen <= lenCnt;
            lenCnt <= 0;
        end
        gapCnt <= frameEvent ? 1 : gapCnt + 1;
        if (frameEvent)
            lastGap <= gapCnt;
        if (watch && !serialDataOe_n && serialDataOut !== prevData) begin
            edgeSeen <= edgeSeen + 1;
            if (bitClkOut !== expLvl)
                edgeBad <= edgeBad + 1;
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            nErrors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One zero-wait bus transfer; the answer is taken at the access edge.
    task apb(input logic w, input logic [4:0] a, input logic [31:0] d,
             input logic [3:0] s);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 8);
        rdata = prdata;
        rerr = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps the next setup from overwriting this release.
        @(posedge clk_sys);
    endtask : apb

    task rd(input logic [4:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0, FULL_STRB);
        chk(nm, e, rdata);
    endtask : rd

    function automatic logic [31:0] ctrl(logic m, logic dbl, logic inv,
                                         logic [2:0] len, logic stop);
        ptap_ctrl_t c;
        c = '{strobeLen:len, cntStop:stop, clkInv:inv, dblClk:dbl,
              master:m, enable:1'b1, default:'0};
        return c;
    endfunction : ctrl

    function automatic logic [31:0] div(logic [9:0] cd);
        ptap_div_t d;
        d = '{frameDiv:11'd80, clkDiv:cd, default:'0};
        return d;
    endfunction : div

    task finish_test();
        if (nErrors == 0 && samplesChecked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial begin
        repeat (40000) @(posedge clk_sys);
        nErrors++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("oeIdle", 3'h7, {bitClkOe_n, frameStrobeOe_n, serialDataOe_n});
        rd(ADDR_CTRL, 32'h0, "ctrl");
        rd(ADDR_DIV, 32'h0, "div");
        rd(ADDR_FDIV, 32'h0, "fdiv");
        apb(1'b1, ADDR_TX1, 32'hA5C3_0F96, FULL_STRB);
        apb(1'b1, ADDR_TX2, 32'h1E2D_3C4B, FULL_STRB);
        apb(1'b1, ADDR_TX1, 32'hFFFF_FFFF, 4'h3);
        chk("strbErr", 32'h1, rerr);
        apb(1'b1, 5'h12, 32'hFFFF_FFFF, FULL_STRB);
        chk("alignErr", 32'h1, rerr);
        rd(ADDR_TX1, 32'hA5C3_0F96, "tx1");
        rd(ADDR_TX2, 32'h1E2D_3C4B, "tx2");
        // Bit period is four system clocks, so a frame is 320 of them.
        apb(1'b1, ADDR_DIV, div(10'h001), FULL_STRB);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, ADDR_CTRL, ctrl(1'b1, 1'b0, 1'b0, k[2:0], 1'b0), FULL_STRB);
            repeat (700) @(posedge clk_sys);
            chk("strobeLen", (k == 0) ? 1 : 8 * k, lastLen);
        end
        chk("masterOe", 32'h0, {bitClkOe_n, frameStrobeOe_n});
        chk("frameGap", 32'd320, lastGap);
        apb(1'b1, ADDR_CTRL, ctrl(1'b1, 1'b1, 1'b0, 3'h0, 1'b0), FULL_STRB);
        repeat (1400) @(posedge clk_sys);
        chk("frameGapDbl", 32'd640, lastGap);
        // Slower clock leaves room for the launch skew of the pins.
        apb(1'b1, ADDR_DIV, div(10'h003), FULL_STRB);
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, ADDR_CTRL, ctrl(1'b1, 1'b0, inv[0], 3'h1, 1'b0), FULL_STRB);
            expLvl <= inv[0];
            repeat (1500) @(posedge clk_sys);
            watch <= 1'b1;
            edgeBad <= 0;
            edgeSeen <= 0;
            repeat (2600) @(posedge clk_sys);
            watch <= 1'b0;
            chk("edgeBad", 32'h0, edgeBad);
            chk("edgeSeen", 32'h1, edgeSeen > 0);
            rd(ADDR_RX1, 32'hA5C3_0F96, "rx1Loop");
            rd(ADDR_RX2, 32'h1E2D_3C4B, "rx2Loop");
        end
        apb(1'b1, ADDR_CTRL, 32'h0, FULL_STRB);
        repeat (4) @(posedge clk_sys);
        chk("oeOff", 3'h7, {bitClkOe_n, frameStrobeOe_n, serialDataOe_n});
        apb(1'b1, ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 3'h0, 1'b1), FULL_STRB);
        repeat (4) @(posedge clk_sys);
        chk("cntStop", 32'h1, mainCntStop);
        apb(1'b0, ADDR_STAT, 32'h0, FULL_STRB);
        chk("statStop", 32'h1, rdata[16]);
        // The sync tick lands five clocks before the first strobe rise; the phase reads four.
        mainTick <= 1'b1;
        @(posedge clk_sys);
        mainTick <= 1'b0;
        repeat (4) @(posedge clk_sys);
        run <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rd(ADDR_STAT, 32'h0000_0004, "statPhase");
        repeat (1600) @(posedge clk_sys);
        chk("cntRun", 32'h0, mainCntStop);
        chk("slaveOe", 32'h3, {bitClkOe_n, frameStrobeOe_n});
        chk("slaveGap", 32'd432, lastGap);
        rd(ADDR_RX1, pattern[63:32], "rx1Slave");
        rd(ADDR_RX2, pattern[31:0], "rx2Slave");
        run <= 1'b0;
        finish_test();
    end
endmodule : ptap_pcm_tdm_audio_port_tb_top
`default_nettype wire
